// ==== monitor_pkg.sv ====
// constants and types for the housekeeping monitor configuration block
package monitor_pkg;

  // ==========================================================================
  // register map (page-0 byte addresses)
  localparam logic [7:0] ADDR_FIRST       = 8'hD9;  // temperature auto-measure control
  localparam logic [7:0] ADDR_BATT_AUTO   = 8'hDA;
  localparam logic [7:0] ADDR_RAIL_UPPER  = 8'hDB;
  localparam logic [7:0] ADDR_RAIL_LOWER  = 8'hDD;
  localparam logic [7:0] ADDR_BATT_UPPER  = 8'hDF;
  localparam logic [7:0] ADDR_BATT_LOWER  = 8'hE1;
  localparam logic [7:0] ADDR_TEMP_UPPER  = 8'hE3;
  localparam logic [7:0] ADDR_TEMP_LOWER  = 8'hE5;
  localparam logic [7:0] ADDR_OVERHEAT    = 8'hE7;
  localparam logic [7:0] ADDR_DETECTOR    = 8'hE8;
  localparam logic [7:0] ADDR_HOLE        = 8'hE9;  // reserved, never written
  localparam logic [7:0] ADDR_AVERAGING   = 8'hEA;
  localparam logic [7:0] ADDR_ALERT_PEND  = 8'hEC;
  localparam logic [7:0] ADDR_OVHT_PEND   = 8'hED;
  localparam int         NUM_BYTES        = 18;     // 0xD9 .. 0xEA

  // byte indices into the register array
  localparam int IDX_TEMP_AUTO = 0;
  localparam int IDX_BATT_AUTO = 1;
  localparam int IDX_LIMITS    = 2;   // six 16-bit limits, low byte first
  localparam int IDX_OVERHEAT  = 14;
  localparam int IDX_DETECTOR  = 15;
  localparam int IDX_HOLE      = 16;
  localparam int IDX_AVERAGING = 17;

  // field positions
  localparam int AUTO_EN_BIT      = 0;
  localparam int PERIOD_LSB       = 4;
  localparam int OVHT_FLAG_BIT    = 0;
  localparam int OVHT_IRQ_EN_BIT  = 4;
  localparam int DET_PD_BIT       = 1;
  localparam int AVG_INT_LSB      = 0;
  localparam int AVG_EXT_LSB      = 3;
  localparam int MARGIN_SHIFT     = 4;
  localparam logic [2:0] AVG_MAX_CODE = 3'h4;  // 16 samples
  localparam logic [11:0] LIMIT_MAX   = 12'hFFF;

  // values after reset, one per byte of the array
  localparam logic [7:0] BYTE_RESET [0:NUM_BYTES-1] = '{
    8'h00, 8'h00,
    8'hFF, 8'h0F, 8'h00, 8'h00,   // rail upper / lower
    8'hFF, 8'h0F, 8'h00, 8'h00,   // battery upper / lower
    8'hFF, 8'h0F, 8'h00, 8'h00,   // temperature upper / lower
    8'h00, 8'h04, 8'h00, 8'h00
  };

  // ==========================================================================
  // timing
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int MILLISECOND_NS  = 1000000;
  localparam int MS_CYCLES       = MILLISECOND_NS / CLOCK_PERIOD_NS;

  // ==========================================================================
  // monitored channels and carriers
  localparam int NUM_CHANNELS = 3;
  localparam logic [1:0] CHAN_RAIL = 2'h0;
  localparam logic [1:0] CHAN_BATT = 2'h1;
  localparam logic [1:0] CHAN_TEMP = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [1:0]  chan;
    logic [11:0] data;
  } conversion_t;

  typedef struct packed {
    logic [NUM_CHANNELS-1:0] high;
    logic [NUM_CHANNELS-1:0] low;
  } alert_t;

endpackage

// ==== monitor_adc_threshold_config.sv ====
// register file, periodic scheduler, averaging and limit checking for the monitor
`timescale 1ns/1ps

module monitor_adc_threshold_config
  import monitor_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  input  wire conversion_t                   conversion,
  input  wire logic [NUM_CHANNELS-1:0][3:0]  channel_margin,
  input  wire logic                          die_overheat_sense,
  output logic                               temperature_measure_req,
  output logic                               battery_measure_req,
  output conversion_t                        averaged,
  output alert_t                             alert,
  output logic                               detector_power_down,
  output logic                               die_overheat_irq,
  output logic      [2:0]                    internal_channel_avg_count,
  output logic      [2:0]                    external_channel_avg_count
);

  // ==========================================================================
  // byte register array
  // one byte per address of the span; the reserved byte inside it is never stored
  logic [7:0] regs [0:NUM_BYTES-1];
  wire  [7:0] rel_addr = reg_addr - ADDR_FIRST;
  wire        in_array = (reg_addr >= ADDR_FIRST) && (reg_addr <= ADDR_AVERAGING);

  // each byte is its own flop group; limits are split low byte then high byte
  // a limit changes one byte at a time, so the host writes both halves before relying on it
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTES; gi++) begin : g_byte
      wire hit = reg_wr && in_array && (rel_addr == 8'(gi)) && (gi != IDX_HOLE);
      // the overheat flag position is never stored so a write cannot fake it
      wire [7:0] keep_mask = (gi == IDX_OVERHEAT) ? 8'h01 : 8'h00;
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          regs[gi] <= BYTE_RESET[gi];
        end else if (hit) begin
          regs[gi] <= reg_wdata & ~keep_mask;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // decoded control fields
  // fields are plain slices of the stored bytes, so software reads back what it wrote
  wire       temperature_periodic_enable = regs[IDX_TEMP_AUTO][AUTO_EN_BIT];
  wire [3:0] temperature_period_exponent = regs[IDX_TEMP_AUTO][PERIOD_LSB +: 4];
  wire       battery_periodic_enable     = regs[IDX_BATT_AUTO][AUTO_EN_BIT];
  wire [3:0] battery_period_exponent     = regs[IDX_BATT_AUTO][PERIOD_LSB +: 4];
  wire       die_overheat_irq_enable     = regs[IDX_OVERHEAT][OVHT_IRQ_EN_BIT];
  wire [2:0] avg_int_code                = regs[IDX_AVERAGING][AVG_INT_LSB +: 3];
  wire [2:0] avg_ext_code                = regs[IDX_AVERAGING][AVG_EXT_LSB +: 3];

  // level outputs come straight from register bits, with no extra stage
  assign detector_power_down        = regs[IDX_DETECTOR][DET_PD_BIT];
  assign internal_channel_avg_count = avg_int_code;
  assign external_channel_avg_count = avg_ext_code;

  // reserved averaging codes fall back to single samples rather than stall
  wire [2:0] avg_shift = (avg_int_code > AVG_MAX_CODE) ? 3'h0 : avg_int_code;

  // ==========================================================================
  // millisecond time base shared by both periodic schedulers
  // free-running, so the first period after enabling is up to one millisecond short;
  // sharing one divider keeps the two schedulers on the same tick
  logic [$clog2(MS_COUNT)-1:0] ms_div;
  wire ms_tick = (ms_div == ($clog2(MS_COUNT))'(MS_COUNT - 1));

  // wraps after MS_COUNT cycles, one tick per millisecond
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_tick ? '0 : ms_div + 1'b1;
    end
  end

  // ==========================================================================
  // periodic request generators: index 0 temperature, 1 battery
  // packed pairs let one generate loop serve both schedulers
  wire [1:0]      sched_en  = {battery_periodic_enable, temperature_periodic_enable};
  wire [1:0][3:0] sched_exp = {battery_period_exponent, temperature_period_exponent};
  logic [1:0]     sched_req;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_sched
      // a 16-bit count covers the longest period of 2^15 milliseconds
      logic [15:0] ms_count;
      wire  [15:0] period_ms = 16'h0001 << sched_exp[gi];
      wire         expire    = ms_tick && (ms_count == period_ms - 16'h0001);
      // disabling clears the count so re-enabling starts a fresh period, its first millisecond possibly short
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          ms_count      <= '0;
          sched_req[gi] <= 1'b0;
        end else begin
          sched_req[gi] <= sched_en[gi] && expire;
          if (!sched_en[gi] || expire) begin
            ms_count <= '0;
          end else if (ms_tick) begin
            ms_count <= ms_count + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // requests are registered one-cycle pulses
  assign temperature_measure_req = sched_req[0];
  assign battery_measure_req     = sched_req[1];

  // ==========================================================================
  // averaging and hysteresis compare, one lane per monitored quantity
  // result_* holds each lane's published mean, *_state its alert levels
  logic [NUM_CHANNELS-1:0]       result_valid;
  logic [NUM_CHANNELS-1:0][11:0] result_data;
  logic [NUM_CHANNELS-1:0]       high_state;
  logic [NUM_CHANNELS-1:0]       low_state;
  logic [NUM_CHANNELS-1:0]       high_prev;
  logic [NUM_CHANNELS-1:0]       low_prev;

  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_lane
      // sixteen full-scale samples fit the 16-bit sum without overflow
      logic [15:0] sum;
      logic [4:0]  count;
      // samples of other lanes and the unused channel code pass by untouched
      wire         take     = conversion.valid && (conversion.chan == 2'(gi));
      wire  [15:0] new_sum  = sum + {4'h0, conversion.data};
      wire  [4:0]  new_cnt  = count + 5'h01;
      // >= rather than == so a code lowered mid-block ends that block on its next sample
      wire  [4:0]  target   = 5'h01 << avg_shift;
      wire         complete = take && (new_cnt >= target);
      wire  [15:0] mean     = new_sum >> avg_shift;

      // limits: upper at the lane's first word, lower right after it
      wire [11:0] upper = {regs[IDX_LIMITS + 4*gi + 1][3:0], regs[IDX_LIMITS + 4*gi]};
      wire [11:0] lower = {regs[IDX_LIMITS + 4*gi + 3][3:0], regs[IDX_LIMITS + 4*gi + 2]};
      // one margin step is 16 counts: the four bits sit just above the lowest nibble
      wire [12:0] margin = {5'h00, channel_margin[gi], 4'h0};

      // 13-bit sums catch overflow, borrow shows as bit 12 on subtraction
      wire [12:0] up_plus  = {1'b0, upper} + margin;
      wire [12:0] up_minus = {1'b0, upper} - margin;
      wire [12:0] lo_plus  = {1'b0, lower} + margin;
      wire [12:0] lo_minus = {1'b0, lower} - margin;
      wire [11:0] hi_set   = up_plus[12]  ? LIMIT_MAX : up_plus[11:0];
      wire [11:0] hi_clr   = up_minus[12] ? 12'h000   : up_minus[11:0];
      wire [11:0] lo_clr   = lo_plus[12]  ? LIMIT_MAX : lo_plus[11:0];
      wire [11:0] lo_set   = lo_minus[12] ? 12'h000   : lo_minus[11:0];
      // thresholds are compared against the published mean, not the raw sample
      wire [11:0] res      = result_data[gi];

      // accumulate until the selected count is reached, then publish the mean
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          sum              <= '0;
          count            <= '0;
          result_valid[gi] <= 1'b0;
          result_data[gi]  <= '0;
        end else begin
          result_valid[gi] <= complete;
          if (complete) begin
            sum             <= '0;
            count           <= '0;
            result_data[gi] <= mean[11:0];
          end else if (take) begin
            sum   <= new_sum;
            count <= new_cnt;
          end
        end
      end

      // between the two thresholds the state holds, giving the hysteresis band
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          high_state[gi] <= 1'b0;
          low_state[gi]  <= 1'b0;
        end else if (result_valid[gi]) begin
          if (res > hi_set) begin
            high_state[gi] <= 1'b1;
          end else if (res <= hi_clr) begin
            high_state[gi] <= 1'b0;
          end
          if (res < lo_set) begin
            low_state[gi] <= 1'b1;
          end else if (res >= lo_clr) begin
            low_state[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // one lane at most completes per cycle, since one sample arrives per cycle;
  // the priority order only keeps the mux free of an unreachable case
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      high_prev <= '0;
      low_prev  <= '0;
      averaged  <= '0;
    end else begin
      high_prev      <= high_state;
      low_prev       <= low_state;
      averaged.valid <= |result_valid;
      averaged.chan  <= result_valid[CHAN_TEMP] ? CHAN_TEMP : result_valid[CHAN_BATT] ? CHAN_BATT : CHAN_RAIL;
      averaged.data  <= result_valid[CHAN_TEMP] ? result_data[CHAN_TEMP] :
                        result_valid[CHAN_BATT] ? result_data[CHAN_BATT] : result_data[CHAN_RAIL];
    end
  end

  // alerts are the raw hysteresis levels; pending bits below catch their rising edges
  assign alert = '{high: high_state, low: low_state};

  // ==========================================================================
  // overheat flag and pending status
  logic       die_overheat_flag;
  logic       overheat_prev;
  logic       overheat_pending;
  logic [7:0] alert_pending;

  // previous copies reset low, matching the idle alert level, so reset makes no false edge
  wire [NUM_CHANNELS-1:0] high_rise = high_state & ~high_prev;
  wire [NUM_CHANNELS-1:0] low_rise  = low_state & ~low_prev;
  // bit layout: 1/2 temperature, 3/4 battery, 5/6 rail; 0 and 7 belong elsewhere
  wire [7:0] alert_events = {1'b0, low_rise[CHAN_RAIL], high_rise[CHAN_RAIL], low_rise[CHAN_BATT],
                             high_rise[CHAN_BATT], low_rise[CHAN_TEMP], high_rise[CHAN_TEMP], 1'b0};
  // write-one-to-clear acts in the write cycle; a set in that same cycle still wins
  wire [7:0] alert_clear  = (reg_wr && reg_addr == ADDR_ALERT_PEND) ? reg_wdata : 8'h00;
  wire       ovht_clear   = reg_wr && (reg_addr == ADDR_OVHT_PEND) && reg_wdata[0];
  // a lasting overheat sets pending once, not again after every clear
  wire       ovht_event   = die_overheat_flag && !overheat_prev;

  // a powered-down detector cannot report, so the flag reads zero then
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      die_overheat_flag <= 1'b0;
      overheat_prev     <= 1'b0;
      overheat_pending  <= 1'b0;
      alert_pending     <= '0;
    end else begin
      die_overheat_flag <= die_overheat_sense && !detector_power_down;
      overheat_prev     <= die_overheat_flag;
      overheat_pending  <= (overheat_pending && !ovht_clear) || ovht_event;
      alert_pending     <= (alert_pending & ~alert_clear) | alert_events;
    end
  end

  // the enable gates only the output, so enabling later still reports an old event
  assign die_overheat_irq = overheat_pending && die_overheat_irq_enable;

  // ==========================================================================
  // read path, one cycle of latency
  // the live flag replaces stored bit 0 of the overheat byte
  wire [7:0] array_byte = (rel_addr == 8'(IDX_OVERHEAT)) ?
                          {regs[IDX_OVERHEAT][7:1], die_overheat_flag} : regs[rel_addr[4:0]];
  // the reserved byte and every address outside the map read zero
  wire [7:0] read_value = (in_array && reg_addr != ADDR_HOLE) ? array_byte :
                          (reg_addr == ADDR_ALERT_PEND) ? alert_pending :
                          (reg_addr == ADDR_OVHT_PEND)  ? {7'h00, overheat_pending} : 8'h00;

  // read data holds until the next read strobe, so the host may pick it up late
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_value;
    end
  end

endmodule

// ==== monitor_adc_threshold_config_properties.sv ====
// port-level checks for the monitor configuration block
`timescale 1ns/1ps
module monitor_props
  import monitor_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic                         clock,
  input wire logic                         rstn,
  input wire logic [7:0]                   reg_addr,
  input wire logic                         reg_wr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_rdata,
  input wire conversion_t                  conversion,
  input wire logic [NUM_CHANNELS-1:0][3:0] channel_margin,
  input wire logic                         die_overheat_sense,
  input wire logic                         temperature_measure_req,
  input wire logic                         battery_measure_req,
  input wire conversion_t                  averaged,
  input wire alert_t                       alert,
  input wire logic                         detector_power_down,
  input wire logic                         die_overheat_irq,
  input wire logic [2:0]                   internal_channel_avg_count,
  input wire logic [2:0]                   external_channel_avg_count
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // assertions
  // holes in the map read zero; the reserved byte is never stored
  wire logic unmapped;
  assign unmapped = reg_addr < ADDR_FIRST || reg_addr == ADDR_HOLE || reg_addr == 8'hEB || reg_addr > ADDR_OVHT_PEND;
  property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_unmapped; reg_rd && unmapped |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_avg_one;
    conversion.valid && conversion.chan != 2'h3 && internal_channel_avg_count == 3'h0 |-> ##2
      averaged.valid && averaged.data == $past(conversion.data, 2) && averaged.chan == $past(conversion.chan, 2);
  endproperty
  a_avg_one: assert property (p_avg_one) else $error("single sample result wrong");
  property p_avg_sel; reg_wr && reg_addr == ADDR_AVERAGING |=>
    {external_channel_avg_count, internal_channel_avg_count} == $past(reg_wdata[5:0]); endproperty
  a_avg_sel: assert property (p_avg_sel) else $error("average counts not updated");
  property p_det_pd; reg_wr && reg_addr == ADDR_DETECTOR |=> detector_power_down == $past(reg_wdata[1]); endproperty
  a_det_pd: assert property (p_det_pd) else $error("detector power bit wrong");
  property p_irq_mask; reg_wr && reg_addr == ADDR_OVERHEAT && !reg_wdata[4] |-> ##2 !die_overheat_irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("overheat irq while disabled");
  property p_treq; temperature_measure_req |=> !temperature_measure_req; endproperty
  a_treq: assert property (p_treq) else $error("temperature request too long");
  property p_breq; battery_measure_req |=> !battery_measure_req; endproperty
  a_breq: assert property (p_breq) else $error("battery request too long");
  property p_auto_off; reg_wr && reg_addr == ADDR_FIRST && !reg_wdata[0] |-> ##2 !temperature_measure_req [*8]; endproperty
  a_auto_off: assert property (p_auto_off) else $error("request after disable");
  c_avg: cover property (averaged.valid);
  c_high: cover property ($rose(alert.high[0]));
  c_irq: cover property (die_overheat_irq);
  c_req: cover property (battery_measure_req);
endmodule

bind monitor_adc_threshold_config monitor_props #(.MS_COUNT(MS_COUNT)) i_props (.clock, .rstn, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .conversion, .channel_margin, .die_overheat_sense, .temperature_measure_req,
  .battery_measure_req, .averaged, .alert, .detector_power_down, .die_overheat_irq, .internal_channel_avg_count,
  .external_channel_avg_count);

// ==== monitor_host.sv ====
// host model that reaches the page-0 registers one byte at a time
`timescale 1ns/1ps
module monitor_host
  import monitor_pkg::*;
(
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ==========================================================================
  // bus cycles: strobes rise after a falling edge and last one rising edge
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // read byte is taken after the edge that accepted the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // a limit is only complete once both bytes went out, low byte first
  task automatic wr_limit(input logic [7:0] a, input logic [11:0] val);
    wr(a, val[7:0]);
    wr(a + 8'h01, {4'h0, val[11:8]});
  endtask
  // keeps the reserved bit 2 at one so the detector config stays legal
  task automatic wr_detector(input logic pd);
    wr(ADDR_DETECTOR, {6'h01, pd, 1'b0});
  endtask
endmodule

// ==== monitor_adc_threshold_config_test.sv ====
// self-checking bench for the monitor configuration block
`timescale 1ns/1ps
module monitor_adc_threshold_config_test;
  import monitor_pkg::*;
  localparam int MS = 10;  // short millisecond keeps periodic runs brief
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, temperature_measure_req, battery_measure_req, detector_power_down, die_overheat_irq;
  logic die_overheat_sense = 1'b0;
  conversion_t conversion = '0;
  conversion_t averaged;
  logic [NUM_CHANNELS-1:0][3:0] channel_margin = '0;
  alert_t alert;
  logic [2:0] internal_channel_avg_count, external_channel_avg_count;
  int failures = 0;
  int comparisons = 0;
  // address, byte written, byte read back
  logic [23:0] reg_rows [19] = '{24'hD9F0F0, 24'hDAE0E0, 24'hDBA5A5, 24'hDCFFFF, 24'hDD5A5A, 24'hDE0303,
    24'hDF1212, 24'hE00E0E, 24'hE13434, 24'hE20000, 24'hE35656, 24'hE40F0F, 24'hE57878, 24'hE60A0A,
    24'hE7FFFE, 24'hE80606, 24'hE97700, 24'hEA2C2C, 24'hEB5500};
  // rail sample in the top twelve bits, expected high and low alert below
  logic [15:0] hys_rows [8] = '{16'h8100, 16'h8112, 16'h7F12, 16'h7F00, 16'h0F00, 16'h0EF1, 16'h10F1, 16'h1100};

  monitor_adc_threshold_config #(.MS_COUNT(MS)) i_dut (.clock, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .conversion, .channel_margin, .die_overheat_sense, .temperature_measure_req, .battery_measure_req,
    .averaged, .alert, .detector_power_down, .die_overheat_irq, .internal_channel_avg_count,
    .external_channel_avg_count);
  monitor_host i_host (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  always #(CLOCK_PERIOD_NS / 2) clock = ~clock;

  // ==========================================================================
  // helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    i_host.rd(a, v);
    check(name, 16'(v), 16'(exp));
  endtask
  task automatic conv(input logic [1:0] ch, input logic [11:0] d);
    @(negedge clock);
    conversion = {1'b1, ch, d};
    @(negedge clock);
    conversion.valid = 1'b0;
  endtask
  // the result pulse lasts one cycle, so every falling edge is looked at
  task automatic wait_avg(input logic [11:0] exp);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clock);
      if (averaged.valid === 1'b1) break;
    end
    if (i == 40) begin
      failures++;
      final_report();
    end
    check("averaged", 16'(averaged.data), 16'(exp));
  endtask
  // waits for one request, then counts the cycles to the next
  task automatic period(input logic sel, input logic [7:0] a, input logic [7:0] d, input int exp);
    int i;
    int n;
    i_host.wr(a, d);
    for (i = 0; i < 2; i++) begin
      for (n = 1; n < 400; n++) begin
        @(negedge clock);
        if ((sel ? battery_measure_req : temperature_measure_req) === 1'b1) break;
      end
      if (n == 400) begin
        failures++;
        final_report();
      end
    end
    check("period", 16'(n), 16'(exp));
    i_host.wr(a, 8'h00);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    int i;
    int k;
    int n;
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    foreach (reg_rows[j]) begin
      i_host.wr(reg_rows[j][23:16], reg_rows[j][15:8]);
      rd_chk(reg_rows[j][23:16], reg_rows[j][7:0], "register");
    end
    check("power down", 16'(detector_power_down), 16'h0001);
    check("counts", 16'({external_channel_avg_count, internal_channel_avg_count}), 16'h002C);
    i_host.wr_detector(1'b0);
    // averaging codes 0 to 5, reserved code 5 last; the first sample carries the rounding
    for (i = 0; i < 6; i++) begin
      i_host.wr(ADDR_AVERAGING, {2'h0, 3'(i), 3'(i)});
      n = (i > 4) ? 1 : (1 << i);
      for (k = 0; k < n; k++) conv(CHAN_BATT, 12'h100 + 12'(i) + (k == 0 ? 12'(n) : 12'h000));
      wait_avg(12'h101 + 12'(i));
    end
    i_host.wr(ADDR_AVERAGING, 8'h00);
    channel_margin[CHAN_RAIL] = 4'h1;
    i_host.wr_limit(ADDR_RAIL_UPPER, 12'h800);
    i_host.wr_limit(ADDR_RAIL_LOWER, 12'h100);
    foreach (hys_rows[j]) begin
      conv(CHAN_RAIL, hys_rows[j][15:4]);
      wait_avg(hys_rows[j][15:4]);
      check("alert", 16'({alert.high[CHAN_RAIL], alert.low[CHAN_RAIL]}), 16'(hys_rows[j][1:0]));
    end
    // a wrapped threshold would flag a full-scale sample
    i_host.wr_limit(ADDR_RAIL_UPPER, 12'hFF8);
    conv(CHAN_RAIL, 12'hFFF);
    wait_avg(12'hFFF);
    check("saturated", 16'(alert.high[CHAN_RAIL]), 16'h0000);
    rd_chk(ADDR_ALERT_PEND, 8'h60, "pending");
    i_host.wr(ADDR_ALERT_PEND, 8'h00);
    rd_chk(ADDR_ALERT_PEND, 8'h60, "pending kept");
    i_host.wr(ADDR_ALERT_PEND, 8'h20);
    rd_chk(ADDR_ALERT_PEND, 8'h40, "pending cleared");
    // temperature lane: a margin wider than both limits clamps the lower thresholds at zero
    channel_margin[CHAN_TEMP] = 4'hF;
    i_host.wr_limit(ADDR_TEMP_UPPER, 12'h050);
    i_host.wr_limit(ADDR_TEMP_LOWER, 12'h000);
    conv(CHAN_TEMP, 12'h141);
    wait_avg(12'h141);
    check("chan", 16'(averaged.chan), 16'(CHAN_TEMP));
    check("temp alert", 16'({alert.high[CHAN_TEMP], alert.low[CHAN_TEMP]}), 16'h0002);
    period(1'b0, ADDR_FIRST, 8'h11, 2 * MS);
    period(1'b1, ADDR_BATT_AUTO, 8'h21, 4 * MS);
    period(1'b1, ADDR_BATT_AUTO, 8'h01, MS);
    i_host.wr(ADDR_OVERHEAT, 8'h00);
    die_overheat_sense = 1'b1;
    repeat (3) @(negedge clock);
    check("irq masked", 16'(die_overheat_irq), 16'h0000);
    rd_chk(ADDR_OVERHEAT, 8'h01, "overheat flag");
    i_host.wr(ADDR_OVERHEAT, 8'h10);
    repeat (2) @(negedge clock);
    check("irq", 16'(die_overheat_irq), 16'h0001);
    i_host.wr_detector(1'b1);
    rd_chk(ADDR_OVERHEAT, 8'h10, "flag powered down");
    i_host.wr(ADDR_OVHT_PEND, 8'h01);
    repeat (2) @(negedge clock);
    check("irq cleared", 16'(die_overheat_irq), 16'h0000);
    die_overheat_sense = 1'b0;
    // second reset in mid-run brings every byte back to its reset value
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    for (i = 0; i < NUM_BYTES; i++) rd_chk(ADDR_FIRST + 8'(i), BYTE_RESET[i], "reset");
    rd_chk(ADDR_ALERT_PEND, 8'h00, "pending reset");
    final_report();
  end
endmodule
